// *** hdl/pcf_pkg.sv ***
// Package of constants for the clock fan-out test control block.
`default_nettype none

package pcf_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_KHZ      = 40000;
   // Longest time allowed to regain lock after the outputs come back.
   localparam int LOCK_TIME_US      = 10000;
   localparam int LOCK_TIMEOUT_CYC  = LOCK_TIME_US * (CLK_FREQ_KHZ / 1000);
   // Lowest reference frequency at which the lock flag is trusted.
   localparam int LOCK_REF_MIN_KHZ  = 10000;
   localparam int LOCK_REF_MAX_CYC  = CLK_FREQ_KHZ / LOCK_REF_MIN_KHZ;
   // Rising edges at most this many cycles apart count as aligned.
   localparam int PHASE_TOL_CYC     = 2;
   // Aligned edge pairs needed before lock is declared.
   localparam int LOCK_MATCHES      = 8;
   localparam int AGE_W             = 8;
   localparam int MATCH_W           = 4;

   // ---------------------------------------------------------------
   // Synchronised pin indices
   // ---------------------------------------------------------------
   localparam int PIN_N    = 5;
   localparam int PIN_REF0 = 0;
   localparam int PIN_REF1 = 1;
   localparam int PIN_FB   = 2;
   localparam int PIN_VCO  = 3;
   localparam int PIN_OE   = 4;

   // ---------------------------------------------------------------
   // APB register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFS_CTRL     = 8'h00;
   localparam logic [7:0]  OFS_STATUS   = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK = 8'h0c;

   // Control register fields.
   localparam int CTRL_PLL_EN  = 0;
   localparam int CTRL_FDIV    = 1;
   localparam int CTRL_REF_SEL = 2;
   localparam logic [2:0] CTRL_RESET = 3'h1;

   // Status register fields.
   localparam int STAT_LOCK    = 0;
   localparam int STAT_OE      = 1;
   localparam int STAT_HOLD    = 2;
   localparam int STAT_RELOCK  = 3;

   // Event bits, shared by the interrupt status and mask registers.
   localparam int EV_N         = 3;
   localparam int EV_LOCKED    = 0;
   localparam int EV_LOST      = 1;
   localparam int EV_TIMEOUT   = 2;

endpackage : pcf_pkg

`default_nettype wire

// *** hdl/pcf_clock_fanout.sv ***
// Digital model of the PLL clock fan-out driver with APB control.
`timescale 1ns/1ps
`default_nettype none

module pcf_clock_fanout #(
   parameter int LOCK_TIMEOUT_CYC = pcf_pkg::LOCK_TIMEOUT_CYC,
   parameter int LOCK_REF_MAX_CYC = pcf_pkg::LOCK_REF_MAX_CYC,
   parameter int LOCK_MATCHES     = pcf_pkg::LOCK_MATCHES,
   parameter int PHASE_TOL_CYC    = pcf_pkg::PHASE_TOL_CYC
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [pcf_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       ref_clk_in,
   input  wire logic                       ref_clk_alt_in,
   input  wire logic                       fb_clk_in,
   input  wire logic                       vco_clk,
   input  wire logic                       oe_rst_n,
   output logic      [4:0]                 main_clk_out,
   output logic                            inv_clk_out,
   output logic                            double_rate_out,
   output logic                            half_rate_out,
   output logic                            clk_out_oe,
   output logic                            lock_out,
   output logic                            pump_up,
   output logic                            pump_down,
   output logic                            irq
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   localparam int TW = $clog2(LOCK_TIMEOUT_CYC + 1);
   localparam logic [TW-1:0] TIMEOUT_LOAD = TW'(LOCK_TIMEOUT_CYC);
   localparam logic [pcf_pkg::AGE_W-1:0] AGE_MAX = '1;
   localparam logic [pcf_pkg::AGE_W-1:0] TOL = pcf_pkg::AGE_W'(PHASE_TOL_CYC);
   localparam logic [pcf_pkg::AGE_W-1:0] REF_MAX = pcf_pkg::AGE_W'(LOCK_REF_MAX_CYC);
   localparam logic [pcf_pkg::MATCH_W-1:0] MATCH_FULL = pcf_pkg::MATCH_W'(LOCK_MATCHES);

   typedef struct packed {
      logic [pcf_pkg::PIN_N-1:0]   sync_a;
      logic [pcf_pkg::PIN_N-1:0]   sync_b;
      logic [pcf_pkg::PIN_N-1:0]   prev;
      logic [2:0]                  ctrl;
      logic                        dist_clk;
      logic                        main_q;
      logic                        half_q;
      logic                        dbl_q;
      logic                        inv_q;
      logic                        hold;
      logic                        oe_q;
      logic                        up;
      logic                        down;
      logic [pcf_pkg::AGE_W-1:0]   ref_age;
      logic [pcf_pkg::AGE_W-1:0]   fb_age;
      logic                        ref_fast;
      logic [pcf_pkg::MATCH_W-1:0] match_cnt;
      logic                        locked;
      logic [TW-1:0]               relock_cnt;
      logic                        relock_run;
      logic [pcf_pkg::EV_N-1:0]    irq_stat;
      logic [pcf_pkg::EV_N-1:0]    irq_mask;
      logic                        irq_q;
      logic [31:0]                 rdata;
   } pcf_state_s;

   pcf_state_s st_reg;
   pcf_state_s st_next;

   // ---------------------------------------------------------------
   // Combinational helpers
   // ---------------------------------------------------------------
   logic                     pll_en;
   logic                     fdiv_one;
   logic                     ref_cur;
   logic                     ref_old;
   logic                     ref_rise;
   logic                     ref_fall;
   logic                     fb_rise;
   logic                     vco_rise;
   logic                     oe_now;
   logic                     dist_rise;
   logic                     aligned;
   logic                     mapped;
   logic                     wr_acc;
   logic                     rd_setup;
   logic [pcf_pkg::EV_N-1:0] ev;
   logic [31:0]              rd_val;

   assign pll_en   = st_reg.ctrl[pcf_pkg::CTRL_PLL_EN];
   assign fdiv_one = st_reg.ctrl[pcf_pkg::CTRL_FDIV];
   assign ref_cur  = st_reg.ctrl[pcf_pkg::CTRL_REF_SEL] ?
                     st_reg.sync_b[pcf_pkg::PIN_REF1] : st_reg.sync_b[pcf_pkg::PIN_REF0];
   assign ref_old  = st_reg.ctrl[pcf_pkg::CTRL_REF_SEL] ?
                     st_reg.prev[pcf_pkg::PIN_REF1] : st_reg.prev[pcf_pkg::PIN_REF0];
   assign ref_rise = ref_cur & ~ref_old;
   assign ref_fall = ~ref_cur & ref_old;
   assign fb_rise  = st_reg.sync_b[pcf_pkg::PIN_FB] & ~st_reg.prev[pcf_pkg::PIN_FB];
   assign vco_rise = st_reg.sync_b[pcf_pkg::PIN_VCO] & ~st_reg.prev[pcf_pkg::PIN_VCO];
   assign oe_now   = st_reg.sync_b[pcf_pkg::PIN_OE];

   assign mapped   = (paddr == pcf_pkg::OFS_CTRL) || (paddr == pcf_pkg::OFS_STATUS) ||
                     (paddr == pcf_pkg::OFS_IRQ_STAT) || (paddr == pcf_pkg::OFS_IRQ_MASK);
   assign wr_acc   = psel & penable & pwrite & mapped;
   assign rd_setup = psel & ~penable & ~pwrite;

   // ---------------------------------------------------------------
   // Read data selection
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (paddr)
         pcf_pkg::OFS_CTRL:     rd_val[2:0] = st_reg.ctrl;
         pcf_pkg::OFS_STATUS:
         begin
            rd_val[pcf_pkg::STAT_LOCK]   = st_reg.locked;
            rd_val[pcf_pkg::STAT_OE]     = st_reg.oe_q;
            rd_val[pcf_pkg::STAT_HOLD]   = st_reg.hold;
            rd_val[pcf_pkg::STAT_RELOCK] = st_reg.relock_run;
         end
         pcf_pkg::OFS_IRQ_STAT: rd_val[pcf_pkg::EV_N-1:0] = st_reg.irq_stat;
         pcf_pkg::OFS_IRQ_MASK: rd_val[pcf_pkg::EV_N-1:0] = st_reg.irq_mask;
         default:               rd_val = 32'h0000_0000;
      endcase
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_next   = st_reg;
      ev        = '0;
      dist_rise = 1'b0;
      aligned   = 1'b0;

      // Two-stage synchronisers, then one stage of history for edges.
      // Only the second stage reads the first, so a metastable sample never reaches logic.
      st_next.sync_a = {oe_rst_n, vco_clk, fb_clk_in, ref_clk_alt_in, ref_clk_in};
      st_next.sync_b = st_reg.sync_a;
      st_next.prev   = st_reg.sync_b;
      st_next.oe_q   = oe_now;

      // Distribution clock source.
      if (!pll_en)
      begin
         st_next.dist_clk = ref_cur;
         st_next.dbl_q    = ~ref_cur;
      end
      else
      begin
         if (fdiv_one)
            st_next.dist_clk = st_reg.sync_b[pcf_pkg::PIN_VCO];
         else if (vco_rise)
            st_next.dist_clk = ~st_reg.dist_clk;
         st_next.dbl_q = st_next.dist_clk;
      end
      dist_rise = st_next.dist_clk & ~st_reg.dist_clk;

      // Output-enable/reset pin and bypass hold-off.
      if (!oe_now)
      begin
         st_next.main_q = 1'b0;
         st_next.half_q = 1'b0;
         st_next.hold   = 1'b1;
      end
      else
      begin
         // In bypass only a reference fall seen with the outputs enabled ends the hold.
         if (st_reg.hold && (pll_en || ref_fall))
            st_next.hold = 1'b0;
         if (!st_reg.hold && dist_rise)
         begin
            // Main is half the distribution rate, half-rate half of main,
            // which fixes every ratio whichever output is fed back.
            st_next.main_q = ~st_reg.main_q;
            if (!st_reg.main_q)
               st_next.half_q = ~st_reg.half_q;
         end
      end

      // The inverted output is registered so that it cannot glitch while gated.
      st_next.inv_q = st_next.oe_q & ~st_next.hold & ~st_next.main_q;

      // Edge ages for the phase detector and reference period check.
      st_next.ref_age = (st_reg.ref_age == AGE_MAX) ? AGE_MAX : st_reg.ref_age + 1'b1;
      st_next.fb_age  = (st_reg.fb_age == AGE_MAX) ? AGE_MAX : st_reg.fb_age + 1'b1;
      if (ref_rise)
      begin
         st_next.ref_age  = '0;
         st_next.ref_fast = (st_reg.ref_age < REF_MAX);
      end
      if (fb_rise)
         st_next.fb_age = '0;

      // The pump levels only show the correction direction; the oscillator input runs free.
      // Rising edges only, so the reference duty cycle does not matter.
      if (ref_rise && fb_rise)
      begin
         st_next.up   = 1'b0;
         st_next.down = 1'b0;
         aligned      = 1'b1;
      end
      else if (ref_rise)
      begin
         aligned      = (st_reg.fb_age < TOL);
         st_next.up   = ~st_reg.down;
         st_next.down = 1'b0;
      end
      else if (fb_rise)
      begin
         aligned      = (st_reg.ref_age < TOL);
         st_next.down = ~st_reg.up;
         st_next.up   = 1'b0;
      end
      if (!pll_en)
      begin
         st_next.up   = 1'b0;
         st_next.down = 1'b0;
      end

      // Lock detection.
      // Below the trusted reference rate the flag stays low even when the edges line up.
      if (!pll_en || !oe_now)
      begin
         st_next.match_cnt = '0;
         st_next.locked    = 1'b0;
      end
      else if (ref_rise || fb_rise)
      begin
         if (aligned)
         begin
            if (st_reg.match_cnt != MATCH_FULL)
               st_next.match_cnt = st_reg.match_cnt + 1'b1;
         end
         else if (ref_rise)
            st_next.match_cnt = '0;
      end
      if (pll_en && oe_now)
         st_next.locked = (st_next.match_cnt == MATCH_FULL) && st_next.ref_fast;
      if (st_next.locked && !st_reg.locked)
         ev[pcf_pkg::EV_LOCKED] = 1'b1;
      if (!st_next.locked && st_reg.locked)
         ev[pcf_pkg::EV_LOST] = 1'b1;

      // Relock timer armed when the outputs come back in PLL mode.
      // A timeout is reported once per return of the outputs; a later lock does not undo it.
      if (oe_now && !st_reg.oe_q && pll_en)
      begin
         st_next.relock_run = 1'b1;
         st_next.relock_cnt = TIMEOUT_LOAD;
      end
      else if (st_reg.relock_run)
      begin
         if (st_reg.locked || !pll_en || !oe_now)
            st_next.relock_run = 1'b0;
         else if (st_reg.relock_cnt == '0)
         begin
            st_next.relock_run       = 1'b0;
            ev[pcf_pkg::EV_TIMEOUT]  = 1'b1;
         end
         else
            st_next.relock_cnt = st_reg.relock_cnt - 1'b1;
      end

      // APB writes; a set in the same cycle beats a write-one clear.
      if (wr_acc)
      begin
         case (paddr)
            pcf_pkg::OFS_CTRL:     st_next.ctrl = pwdata[2:0];
            pcf_pkg::OFS_IRQ_STAT: st_next.irq_stat = st_reg.irq_stat &
                                                     ~pwdata[pcf_pkg::EV_N-1:0];
            pcf_pkg::OFS_IRQ_MASK: st_next.irq_mask = pwdata[pcf_pkg::EV_N-1:0];
            default:               st_next.ctrl = st_reg.ctrl;
         endcase
      end
      st_next.irq_stat = st_next.irq_stat | ev;
      st_next.irq_q    = |(st_next.irq_stat & st_next.irq_mask);

      // No wait states: read data is captured in the setup cycle and stands until the next read.
      if (rd_setup)
         st_next.rdata = rd_val;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg            <= '0;
         st_reg.ctrl       <= pcf_pkg::CTRL_RESET;
         st_reg.hold       <= 1'b1;
         st_reg.ref_age    <= '1;
         st_reg.fb_age     <= '1;
      end
      else
         st_reg <= st_next;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Disabled main, inverted and half-rate outputs sit low here, double_rate_out keeps running; clk_out_oe is the pad enable that tri-states them.
   assign prdata          = st_reg.rdata;
   assign pready          = 1'b1;
   assign pslverr         = psel & penable & ~mapped;
   assign main_clk_out    = {5{st_reg.main_q}};
   assign inv_clk_out     = st_reg.inv_q;
   assign double_rate_out = st_reg.dbl_q;
   assign half_rate_out   = st_reg.half_q;
   assign clk_out_oe      = st_reg.oe_q;
   assign lock_out        = st_reg.locked;
   assign pump_up         = st_reg.up;
   assign pump_down       = st_reg.down;
   assign irq             = st_reg.irq_q;

endmodule // pcf_clock_fanout

`default_nettype wire

// *** tb/pcf_clock_fanout_monitor.sv ***
// Port-level assertions for the clock fan-out block.
`timescale 1ns/1ps
`default_nettype none
module pcf_clock_fanout_monitor (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [pcf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                pwdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       ref_clk_in,
   input wire logic                       oe_rst_n,
   input wire logic [4:0]                 main_clk_out,
   input wire logic                       inv_clk_out,
   input wire logic                       double_rate_out,
   input wire logic                       half_rate_out,
   input wire logic                       clk_out_oe,
   input wire logic                       lock_out,
   input wire logic                       irq
);
   logic [2:0] ctrl_reg;
   logic       byp;
   // Shadow of the control word, so the bypass checks know the mode.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= pcf_pkg::CTRL_RESET;
      else if (psel && penable && pwrite && pready && paddr == pcf_pkg::OFS_CTRL)
         ctrl_reg <= pwdata[2:0];
   end
   assign byp = !ctrl_reg[0] && !ctrl_reg[2];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_outputs_off: assert property (!clk_out_oe && $past(!clk_out_oe) |-> main_clk_out == 5'h00 && !half_rate_out)
      else $error("clock outputs active while disabled");
   a_oe_drop: assert property ($fell(oe_rst_n) |-> ##[2:4] !clk_out_oe)
      else $error("outputs not disabled after enable pin low");
   a_oe_restore: assert property ($rose(oe_rst_n) |-> ##[2:4] clk_out_oe)
      else $error("outputs not enabled after enable pin high");
   a_lock_lost: assert property (!clk_out_oe && $past(!clk_out_oe) |-> !lock_out)
      else $error("lock reported with outputs disabled");
   a_main_equal: assert property (main_clk_out == {5{main_clk_out[0]}})
      else $error("main outputs differ");
   a_inv_main: assert property (clk_out_oe && main_clk_out[0] |-> !inv_clk_out)
      else $error("inverted output not opposite main");
   a_bypass_fall: assert property (byp && $rose(ref_clk_in) |-> ##[2:4] !double_rate_out)
      else $error("double rate not low after reference rise");
   a_bypass_rise: assert property (byp && $fell(ref_clk_in) |-> ##[2:4] double_rate_out)
      else $error("double rate not high after reference fall");
   a_hold_low: assert property (byp && $rose(clk_out_oe) |-> (main_clk_out == 5'h00 && !half_rate_out)[*3])
      else $error("outputs not held low after enable");
   a_ready_high: assert property (psel |-> pready)
      else $error("ready low during transfer");
   a_unmapped_err: assert property (psel && penable && paddr > pcf_pkg::OFS_IRQ_MASK |-> pslverr)
      else $error("no error on unmapped address");
   cover property ($rose(irq));
   cover property ($fell(clk_out_oe));
   cover property (byp && $rose(ref_clk_in));
   cover property (pslverr);
endmodule // pcf_clock_fanout_monitor

bind pcf_clock_fanout pcf_clock_fanout_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .ref_clk_in(ref_clk_in), .oe_rst_n(oe_rst_n), .main_clk_out(main_clk_out),
   .inv_clk_out(inv_clk_out), .double_rate_out(double_rate_out), .half_rate_out(half_rate_out),
   .clk_out_oe(clk_out_oe), .lock_out(lock_out), .irq(irq));
`default_nettype wire

// *** tb/pcf_ref_source.sv ***
// Reference clock source and board feedback wiring for the fan-out block.
`timescale 1ns/1ps
`default_nettype none
module pcf_ref_source (
   input  wire logic [4:0] main_clk,
   input  wire logic       half_clk,
   input  wire logic       dbl_clk,
   input  wire logic       drive,
   input  wire logic [1:0] fb_sel,
   output logic            ref_clk,
   output logic            fb_clk
);
   // Free running 5 MHz reference with an uneven duty cycle.
   initial
   begin
      ref_clk = 1'b0;
      #7;
      forever
      begin
         #75 ref_clk = 1'b1;
         #125 ref_clk = 1'b0;
      end
   end
   // The feedback pin has a pull-down, so a disabled output reads low.
   assign fb_clk = !drive ? 1'b0 : fb_sel == 2'h0 ? main_clk[4] :
                   fb_sel == 2'h1 ? half_clk : fb_sel == 2'h2 ? dbl_clk : main_clk[0];
endmodule // pcf_ref_source
`default_nettype wire

// *** tb/pcf_clock_fanout_tb.sv ***
// Self-checking bench for the clock fan-out test control block.
`timescale 1ns/1ps
`default_nettype none
module pcf_clock_fanout_tb;
   logic        pclk = 1'b0, presetn = 1'b0, vco_clk = 1'b0, oe_rst_n = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, q;
   logic [1:0]  fb_sel = 2'h0;
   logic [3:0]  alt_div = 4'h0;
   logic [4:0]  main_clk_out;
   logic        pready, pslverr, ref_clk, fb_clk, inv_clk_out, double_rate_out, half_rate_out;
   logic        clk_out_oe, lock_out, irq, se, pump_up, pump_down;
   int          errors = 0, comparisons = 0, nd, nm, nh, nv, nr, np;

   always #12.5 pclk = ~pclk;
   // Test clock on the second reference input, one sixteenth of the bus clock.
   always @(posedge pclk) alt_div <= alt_div + 4'h1;
   initial
   begin
      #11;
      forever #75 vco_clk = ~vco_clk;
   end

   pcf_clock_fanout #(.LOCK_TIMEOUT_CYC(200)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(q),
      .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk), .ref_clk_alt_in(alt_div[3]),
      .fb_clk_in(fb_clk), .vco_clk(vco_clk), .oe_rst_n(oe_rst_n), .main_clk_out(main_clk_out),
      .inv_clk_out(inv_clk_out), .double_rate_out(double_rate_out), .half_rate_out(half_rate_out),
      .clk_out_oe(clk_out_oe), .lock_out(lock_out), .pump_up(pump_up), .pump_down(pump_down),
      .irq(irq));
   pcf_ref_source u_src (.main_clk(main_clk_out), .half_clk(half_rate_out),
      .dbl_clk(double_rate_out), .drive(clk_out_oe), .fb_sel(fb_sel), .ref_clk(ref_clk),
      .fb_clk(fb_clk));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_n(input string n, input int e, input int g);
      comparisons++;
      if (g < e - 2 || g > e + 2)
      begin
         errors++;
         $display("unexpected %s exp %0d got %0d", n, e, g);
      end
   endtask
   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic count(input int cyc);
      logic pd, pm, ph, pv, pr;
      {nd, nm, nh, nv, nr, np} = '0;
      {pd, pm, ph, pv, pr} = {double_rate_out, main_clk_out[0], half_rate_out, vco_clk, ref_clk};
      repeat (cyc)
      begin
         @(posedge pclk);
         nd += int'(double_rate_out && !pd);
         nm += int'(main_clk_out[0] && !pm);
         nh += int'(half_rate_out && !ph);
         nv += int'(vco_clk && !pv);
         nr += int'(ref_clk && !pr);
         np += int'(pump_up || pump_down);
         {pd, pm, ph, pv, pr} = {double_rate_out, main_clk_out[0], half_rate_out, vco_clk, ref_clk};
      end
   endtask
   task automatic t_regs();
      apb(1'b0, pcf_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h1, q);
      apb(1'b0, pcf_pkg::OFS_IRQ_MASK, 32'h0);
      chk("mask reset", 32'h0, q);
      apb(1'b1, 8'h10, 32'hf);
      chk("unmapped err", 32'h1, se);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped rd", 32'h0, q);
      $display("test regs done");
   endtask
   task automatic t_ratio();
      apb(1'b1, pcf_pkg::OFS_CTRL, 32'h3);
      for (int s = 0; s < 4; s++)
      begin
         fb_sel <= 2'(s);
         count(1200);
         chk_n("double vs vco", nv, nd);
         chk_n("double vs main", nd, 2 * nm);
         chk_n("main vs half", nm, 2 * nh);
         chk("pump active", 32'h1, np > 0);
      end
      apb(1'b1, pcf_pkg::OFS_CTRL, 32'h1);
      count(1200);
      chk_n("divided double", nv, 2 * nd);
      $display("test ratio done");
   endtask
   task automatic t_bypass();
      apb(1'b1, pcf_pkg::OFS_CTRL, 32'h0);
      oe_rst_n <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("oe low", 32'h0, {clk_out_oe, main_clk_out, half_rate_out, lock_out});
      while (ref_clk !== 1'b1) @(posedge pclk);
      while (ref_clk !== 1'b0) @(posedge pclk);
      oe_rst_n <= 1'b1;
      while (ref_clk !== 1'b1) @(posedge pclk);
      repeat (4) @(posedge pclk);
      chk("held outputs", 32'h100, {clk_out_oe, main_clk_out, half_rate_out, inv_clk_out,
          double_rate_out});
      count(800);
      chk_n("bypass main", nr, 2 * nm);
      chk_n("bypass double", nr, nd);
      chk("pumps idle", 32'h0, np);
      apb(1'b1, pcf_pkg::OFS_CTRL, 32'h4);
      repeat (5) @(posedge pclk);
      count(320);
      chk_n("alt double", 320 / 16, nd);
      chk_n("alt main", 320 / 16, 2 * nm);
      $display("test bypass done");
   endtask
   task automatic t_irq();
      apb(1'b1, pcf_pkg::OFS_CTRL, 32'h3);
      apb(1'b1, pcf_pkg::OFS_IRQ_STAT, 32'h7);
      oe_rst_n <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("lock while off", 32'h0, lock_out);
      oe_rst_n <= 1'b1;
      repeat (150) @(posedge pclk);
      apb(1'b0, pcf_pkg::OFS_IRQ_STAT, 32'h0);
      chk("early timeout", 32'h0, q[2]);
      repeat (100) @(posedge pclk);
      apb(1'b0, pcf_pkg::OFS_IRQ_STAT, 32'h0);
      chk("relock timeout", 32'h2, {q[2], irq});
      apb(1'b1, pcf_pkg::OFS_IRQ_MASK, 32'h4);
      repeat (3) @(posedge pclk);
      chk("irq unmasked", 32'h1, irq);
      apb(1'b1, pcf_pkg::OFS_CTRL, 32'h2);
      apb(1'b1, pcf_pkg::OFS_IRQ_STAT, 32'h4);
      repeat (3) @(posedge pclk);
      apb(1'b0, pcf_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq cleared", 32'h0, {q[2], irq});
      $display("test irq done");
   endtask
   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      #(30000 * 25);
      errors++;
      close_out();
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_ratio();
      t_bypass();
      t_irq();
      close_out();
   end
endmodule // pcf_clock_fanout_tb
`default_nettype wire
